/* core/bms_cmd_core.sv */
// Command interpreter, configuration store and access levels
`timescale 1ns/10ps
module bms_cmd_core #(
    parameter int unsigned BUS_RST_CYC = bms_cmd_pkg::BUS_RST_CYC_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic filt_en,
    input wire bms_cmd_pkg::pwr_mode_t pwr_mode,
    output logic miso,
    output logic miso_oe,
    output bms_cmd_pkg::sec_t sec_level,
    output logic cfg_ready,
    output logic sig_mismatch,
    output logic bus_reset_evt,
    output logic cmd_refused,
    output logic [7:0] ctrl_out
);
    import bms_cmd_pkg::*;

    typedef enum logic [1:0] {st_off, st_load, st_idle, st_sig} state_t;
    typedef enum logic [1:0] {key_none, key_ua, key_fa} key_t;
    typedef enum logic [1:0] {op_irom, op_drom, op_chk, op_store} sig_op_t;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    cmd_link_if lnk ();

    logic cs_s1_r, cs_s2_r, sclk_s1_r, sclk_s2_r, tog_s1_r, tog_s2_r, tog_s3_r;
    logic sclk_f_r, sclk_fd_r, bus_rst_r, otp_prog_r, stored_ok_r;
    logic [FILT_W-1:0] filt_cnt_r;
    logic [31:0] act_cnt_r;
    logic [2:0] rst_age_r;
    logic [7:0] cfg_r [CFG_N];
    logic [7:0] otp_r [CFG_N];
    logic [7:0] blk_r [BLK_N];
    logic [CFG_N*8-1:0] cfg_flat;
    logic [CFG_AW-1:0] load_idx_r;
    logic [7:0] sub_lo_r, resp_nxt;
    logic [15:0] stored_sig_r, sub_code, eng_sig;
    state_t st_r;
    key_t key_r;
    sig_op_t op_r;
    logic hit, evt, wr, is_cfg, is_blk, sub_ok, wr_ok, refuse, sub_go, sig_start;
    logic eng_busy, eng_done;
    logic [6:0] addr;
    logic [7:0] data;

    bms_spi_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .lnk(lnk.link),
        .miso(miso),
        .miso_oe(miso_oe)
    );

    bms_sig_engine u_sig (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .start(sig_start),
        .src(sub_code == SUB_IROM_SIG ? src_irom
            : (sub_code == SUB_DROM_SIG ? src_drom : src_cfg)),
        .cfg(cfg_flat),
        .busy(eng_busy),
        .done(eng_done),
        .sig(eng_sig)
    );

    generate
        for (genvar i = 0; i < CFG_N; i++) begin : g_flat
            assign cfg_flat[i*8 +: 8] = cfg_r[i];
        end
    endgenerate

    assign lnk.lrst = bus_rst_r;
    assign addr = lnk.word[14:8];
    assign data = lnk.word[7:0];
    assign sub_code = {data, sub_lo_r};
    assign evt = (tog_s2_r ^ tog_s3_r) & ~bus_rst_r;
    assign wr = evt & ~lnk.word[15];
    assign is_cfg = addr >= CMD_CFG_BASE && addr < CMD_CFG_BASE + 7'(CFG_N);
    assign is_blk = addr >= CMD_BLK_BASE && addr < CMD_BLK_BASE + 7'(BLK_N);
    assign hit = !cs_s2_r && !bus_rst_r && act_cnt_r == 32'(BUS_RST_CYC - 1);

    // Pin and link toggle synchronisers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            {cs_s1_r, cs_s2_r} <= 2'b11;
            {sclk_s1_r, sclk_s2_r, tog_s1_r, tog_s2_r, tog_s3_r} <= 5'h0;
        end else if (ce) begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            sclk_s1_r <= sclk;
            sclk_s2_r <= sclk_s1_r;
            tog_s1_r <= lnk.tog;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
        end
    end

    // Activity filter on the clock pin
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sclk_f_r <= 1'b0;
            filt_cnt_r <= '0;
        end else if (ce) begin
            if (!filt_en || sclk_s2_r == sclk_f_r) begin
                filt_cnt_r <= '0;
                sclk_f_r <= sclk_s2_r;
            end else if (filt_cnt_r == FILT_W'(FILT_CYC - 1)) begin
                filt_cnt_r <= '0;
                sclk_f_r <= sclk_s2_r;
            end else begin
                filt_cnt_r <= filt_cnt_r + 1'b1;
            end
        end
    end

    // Inactivity timeout and interface reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sclk_fd_r <= 1'b0;
            act_cnt_r <= 32'h0;
            bus_rst_r <= 1'b1;
            rst_age_r <= 3'h0;
            bus_reset_evt <= 1'b0;
        end else if (ce) begin
            sclk_fd_r <= sclk_f_r;
            if (cs_s2_r || bus_rst_r || sclk_f_r != sclk_fd_r) begin
                act_cnt_r <= 32'h0;
            end else if (!hit) begin
                act_cnt_r <= act_cnt_r + 32'h1;
            end
            bus_reset_evt <= hit;
            rst_age_r <= bus_rst_r ? rst_age_r + 3'h1 : 3'h0;
            // Held until select rises and the toggle path has settled
            if (hit) begin
                bus_rst_r <= 1'b1;
            end else if (cs_s2_r && &rst_age_r) begin
                bus_rst_r <= 1'b0;
            end
        end
    end

    // Write and subcommand admission by access level
    always_comb begin
        unique case (sub_code)
            SUB_SEAL, SUB_KEY_UA, SUB_KEY_UB, SUB_KEY_FA, SUB_KEY_FB: sub_ok = 1'b1;
            SUB_IROM_SIG, SUB_DROM_SIG, SUB_CFG_CHK: sub_ok = 1'b1;
            SUB_CFG_STORE: sub_ok = sec_level != restricted_level;
            SUB_OTP_WRITE: sub_ok = sec_level == full_access_level;
            default: sub_ok = 1'b0;
        endcase
        wr_ok = st_r == st_idle && (addr == CMD_CTRL || is_blk || addr == CMD_SUB_LO
            || (is_cfg && sec_level != restricted_level)
            || (addr == CMD_SUB_HI && sub_ok));
        refuse = wr && !wr_ok;
        sub_go = wr && wr_ok && addr == CMD_SUB_HI;
        sig_start = sub_go && (sub_code == SUB_IROM_SIG || sub_code == SUB_DROM_SIG
            || sub_code == SUB_CFG_CHK || sub_code == SUB_CFG_STORE);
    end

    // Power state, configuration store and programming
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= st_load;
            load_idx_r <= '0;
            cfg_ready <= 1'b0;
            otp_prog_r <= 1'b0;
            for (int i = 0; i < CFG_N; i++) begin
                cfg_r[i] <= 8'h00;
                otp_r[i] <= 8'h00;
            end
        end else if (ce) begin
            if (pwr_mode == pwr_shutdown) begin
                st_r <= st_off;
                cfg_ready <= 1'b0;
                for (int i = 0; i < CFG_N; i++) begin
                    cfg_r[i] <= 8'h00;
                end
            end else begin
                unique case (st_r)
                    st_off: begin
                        st_r <= st_load;
                        load_idx_r <= '0;
                    end
                    st_load: begin
                        cfg_r[load_idx_r] <= otp_prog_r ? otp_r[load_idx_r]
                            : CFG_DEFAULT[{load_idx_r, 3'h0} +: 8];
                        load_idx_r <= load_idx_r + 1'b1;
                        if (load_idx_r == CFG_AW'(CFG_N - 1)) begin
                            st_r <= st_idle;
                            cfg_ready <= 1'b1;
                        end
                    end
                    st_idle: begin
                        if (sig_start) begin
                            st_r <= st_sig;
                        end
                        if (wr && wr_ok && is_cfg) begin
                            cfg_r[addr[CFG_AW-1:0]] <= data;
                        end
                        if (sub_go && sub_code == SUB_OTP_WRITE) begin
                            otp_prog_r <= 1'b1;
                            for (int i = 0; i < CFG_N; i++) begin
                                otp_r[i] <= cfg_r[i];
                            end
                        end
                    end
                    st_sig: begin
                        if (eng_done) begin
                            st_r <= st_idle;
                        end
                    end
                endcase
            end
        end
    end

    // Access level and key sequencing
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_level <= restricted_level;
            key_r <= key_none;
        end else if (ce) begin
            if (pwr_mode == pwr_shutdown) begin
                sec_level <= restricted_level;
                key_r <= key_none;
            end else if (sub_go) begin
                key_r <= key_none;
                unique case (sub_code)
                    SUB_SEAL: sec_level <= restricted_level;
                    SUB_KEY_UA: key_r <= key_ua;
                    SUB_KEY_FA: key_r <= key_fa;
                    SUB_KEY_UB: begin
                        if (key_r == key_ua && sec_level == restricted_level) begin
                            sec_level <= intermediate_level;
                        end
                    end
                    SUB_KEY_FB: begin
                        if (key_r == key_fa && sec_level == intermediate_level) begin
                            sec_level <= full_access_level;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Block buffer, subcommand pointer and signature results
    always_ff @(posedge clk) begin
        if (!nrst || (ce && pwr_mode == pwr_shutdown)) begin
            for (int i = 0; i < BLK_N; i++) begin
                blk_r[i] <= 8'h00;
            end
            sub_lo_r <= 8'h00;
            ctrl_out <= CTRL_RST;
            op_r <= op_irom;
            stored_sig_r <= 16'h0;
            stored_ok_r <= 1'b0;
            sig_mismatch <= 1'b0;
            cmd_refused <= 1'b0;
        end else if (ce) begin
            cmd_refused <= refuse;
            if (wr && wr_ok && addr == CMD_CTRL) begin
                ctrl_out <= data;
            end
            if (wr && wr_ok && addr == CMD_SUB_LO) begin
                sub_lo_r <= data;
            end
            if (wr && wr_ok && is_blk) begin
                blk_r[addr[2:0]] <= data;
            end
            if (sig_start) begin
                op_r <= sub_code == SUB_IROM_SIG ? op_irom : sub_code == SUB_DROM_SIG ? op_drom
                    : sub_code == SUB_CFG_CHK ? op_chk : op_store;
            end
            if (eng_done) begin
                blk_r[0] <= eng_sig[7:0];
                blk_r[1] <= eng_sig[15:8];
                if (op_r == op_store) begin
                    stored_sig_r <= eng_sig;
                    stored_ok_r <= 1'b1;
                end else if (op_r == op_chk) begin
                    sig_mismatch <= !stored_ok_r || eng_sig != stored_sig_r;
                    blk_r[2] <= {7'h0, !stored_ok_r || eng_sig != stored_sig_r};
                end
            end
        end
    end

    // Read answer, held steady while a frame is in progress
    always_comb begin
        resp_nxt = 8'h00;
        if (addr == CMD_STATUS) begin
            resp_nxt[ST_SEC_LSB +: 2] = sec_level;
            resp_nxt[ST_READY] = cfg_ready;
            resp_nxt[ST_MISMATCH] = sig_mismatch;
            resp_nxt[ST_BUSY] = eng_busy;
            resp_nxt[ST_OTP] = otp_prog_r;
        end else if (addr == CMD_CTRL) begin
            resp_nxt = ctrl_out;
        end else if (is_cfg && sec_level != restricted_level) begin
            resp_nxt = cfg_r[addr[CFG_AW-1:0]];
        end else if (is_blk) begin
            resp_nxt = blk_r[addr[2:0]];
        end else if (addr == CMD_SUB_LO) begin
            resp_nxt = sub_lo_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lnk.resp <= 8'h00;
        end else if (ce && cs_s2_r) begin
            lnk.resp <= resp_nxt;
        end
    end

    AST_BUS_RST: assert property (bus_reset_evt |-> $past(!cs_s2_r) && bus_rst_r)
        else $error("bus reset without idle select");
    AST_FILT: assert property (filt_en && ce && sclk_f_r != $past(sclk_f_r) && $past(filt_en)
        |-> $past(filt_cnt_r) == FILT_W'(FILT_CYC - 1))
        else $error("filter passed a short pulse");
    AST_LOAD: assert property ($rose(cfg_ready) |-> $past(st_r) == st_load)
        else $error("ready without load");
    AST_RETAIN: assert property (pwr_mode != pwr_shutdown && st_r == st_idle
        && !(wr && wr_ok && is_cfg) |=> $stable(cfg_flat))
        else $error("configuration changed without write");
    AST_SHUTDOWN: assert property (ce && pwr_mode == pwr_shutdown
        |=> cfg_flat == '0 && !cfg_ready && sec_level == restricted_level)
        else $error("shutdown did not clear");
    AST_RESTRICT: assert property (ce && wr && is_cfg && sec_level == restricted_level
        |=> $stable(cfg_flat) && cmd_refused)
        else $error("restricted memory write taken");
    AST_UNSEAL_WR: assert property (ce && wr && is_cfg && st_r == st_idle
        && sec_level != restricted_level |=> cfg_r[$past(addr[CFG_AW-1:0])] == $past(data))
        else $error("memory write lost");
    AST_OTP: assert property ($rose(otp_prog_r) |-> $past(sec_level) == full_access_level)
        else $error("programming outside full access");
    AST_KEYS: assert property ($past(sec_level) == restricted_level
        && sec_level == intermediate_level
        |-> $past(sub_go && sub_code == SUB_KEY_UB && key_r == key_ua))
        else $error("level raised without keys");
    AST_SIG_DONE: assert property (sig_start && ce |-> ##[1:20] eng_done)
        else $error("signature never finished");
    AST_REFUSE: assert property (ce && refuse |=> $stable(sec_level) && $stable(cfg_flat)
        && $stable(ctrl_out) && cmd_refused)
        else $error("refused request changed state");

    COV_UNSEAL: cover property (sec_level == intermediate_level);
    COV_FULL: cover property (sec_level == full_access_level);
    COV_CHK: cover property (eng_done && op_r == op_chk);
    COV_TIMEOUT: cover property (bus_reset_evt);
endmodule

/* core/bms_cmd_pkg.sv */
// Shared constants and types for the battery monitor command front end
package bms_cmd_pkg;
    typedef enum logic [1:0] {pwr_normal, pwr_sleep, deep_low_power_mode, pwr_shutdown} pwr_mode_t;
    typedef enum logic [1:0] {restricted_level, intermediate_level, full_access_level} sec_t;
    typedef enum logic [1:0] {src_irom, src_drom, src_cfg} sig_src_t;

    localparam int CLK_MHZ = 100;
    // Bus inactivity reset window, 1.9 s to 2.1 s
    localparam int BUS_RST_MIN_MS = 1900;
    localparam int BUS_RST_MAX_MS = 2100;
    localparam int unsigned BUS_RST_CYC_DEF = BUS_RST_MIN_MS * 1000 * CLK_MHZ;
    // Glitch width rejected by the pin filter
    localparam int FILT_NS = 200;
    localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT_W = 5;

    // Direct command addresses (7-bit space)
    localparam logic [6:0] CMD_STATUS = 7'h00;
    localparam logic [6:0] CMD_CTRL = 7'h01;
    localparam logic [6:0] CMD_CFG_BASE = 7'h10;
    localparam logic [6:0] CMD_SUB_LO = 7'h3e;
    localparam logic [6:0] CMD_SUB_HI = 7'h3f;
    localparam logic [6:0] CMD_BLK_BASE = 7'h40;
    localparam int CFG_N = 8;
    localparam int CFG_AW = 3;
    localparam int BLK_N = 8;
    localparam int CAL_FIRST = 6;
    localparam int ROM_N = 16;

    // Status byte fields
    localparam int ST_SEC_LSB = 0;
    localparam int ST_READY = 2;
    localparam int ST_MISMATCH = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_OTP = 5;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [CFG_N*8-1:0] CFG_DEFAULT = 64'h0807_0605_0403_0201;

    // Subcommand codes; key values are arbitrary
    localparam logic [15:0] SUB_SEAL = 16'h0030;
    localparam logic [15:0] SUB_KEY_UA = 16'h1234;
    localparam logic [15:0] SUB_KEY_UB = 16'h5678;
    localparam logic [15:0] SUB_KEY_FA = 16'h9abc;
    localparam logic [15:0] SUB_KEY_FB = 16'hdef0;
    localparam logic [15:0] SUB_IROM_SIG = 16'h0009;
    localparam logic [15:0] SUB_DROM_SIG = 16'h000a;
    localparam logic [15:0] SUB_CFG_CHK = 16'h000b;
    localparam logic [15:0] SUB_CFG_STORE = 16'h000c;
    localparam logic [15:0] SUB_OTP_WRITE = 16'h00a0;
endpackage

/* core/cmd_link_if.sv */
// Carrier between the serial link logic and the command core
`timescale 1ns/10ps
interface cmd_link_if;
    logic [15:0] word;
    logic tog;
    logic [7:0] resp;
    logic lrst;
    modport link (output word, output tog, input resp, input lrst);
    modport core (input word, input tog, output resp, output lrst);
endinterface

/* core/bms_spi_link.sv */
// Serial target logic clocked by the host serial clock
`timescale 1ns/10ps
module bms_spi_link (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    cmd_link_if.link lnk,
    output logic miso,
    output logic miso_oe
);
    logic clr;
    logic [3:0] bit_cnt_r;
    logic [14:0] shift_r;
    logic [15:0] word_r;
    logic tog_r;

    assign clr = cs_n | lnk.lrst;
    assign lnk.word = word_r;
    assign lnk.tog = tog_r;

    // Bit counter restarts with every frame or bus reset
    always_ff @(posedge sclk or posedge clr) begin
        if (clr) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 15'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r <= {shift_r[13:0], mosi};
        end
    end

    // Completed word and its toggle event
    always_ff @(posedge sclk or posedge lnk.lrst) begin
        if (lnk.lrst) begin
            word_r <= 16'h0;
            tog_r <= 1'b0;
        end else if (bit_cnt_r == 4'hf) begin
            word_r <= {shift_r, mosi};
            tog_r <= ~tog_r;
        end
    end

    // Response shifted out MSB first in the second byte
    always_ff @(negedge sclk or posedge clr) begin
        if (clr) begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= 1'b1;
            miso <= bit_cnt_r[3] ? lnk.resp[~bit_cnt_r[2:0]] : 1'b0;
        end
    end
endmodule

/* core/bms_sig_engine.sv */
// Signature walker over the ROMs or the static configuration bytes
`timescale 1ns/10ps
module bms_sig_engine (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic start,
    input wire bms_cmd_pkg::sig_src_t src,
    input wire logic [bms_cmd_pkg::CFG_N*8-1:0] cfg,
    output logic busy,
    output logic done,
    output logic [15:0] sig
);
    import bms_cmd_pkg::*;
    logic [3:0] idx_r;
    logic [3:0] last;
    logic [7:0] cur;
    sig_src_t src_r;

    // Fixed ROM images
    function automatic logic [7:0] rom_byte(input sig_src_t s, input logic [3:0] i);
        logic [7:0] b;
        b = (s == src_irom) ? (8'h5a ^ {i, ~i}) : ({i, i} + 8'h31);
        return b;
    endfunction

    assign cur = (src_r == src_cfg) ? cfg[{idx_r[CFG_AW-1:0], 3'h0} +: 8] : rom_byte(src_r, idx_r);
    assign last = (src_r == src_cfg) ? 4'(CAL_FIRST - 1) : 4'(ROM_N - 1);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy <= 1'b0;
            done <= 1'b0;
            idx_r <= 4'h0;
            sig <= 16'h0;
            src_r <= src_irom;
        end else if (ce) begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                idx_r <= 4'h0;
                sig <= 16'hffff;
                src_r <= src;
            end else if (busy) begin
                sig <= {sig[14:0], sig[15]} ^ {cur, cur ^ {4'h0, idx_r}};
                idx_r <= idx_r + 4'h1;
                if (idx_r == last) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

/* test/host_spi_model.sv */
// Host serial controller model driving framed 16-bit words
`timescale 1ns/10ps
module host_spi_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Select change plus lead time before any clock edge
    task automatic sel(input logic v);
        cs_n = v;
        #643;
    endtask
    // Pulse of a given width on the clock pin
    task automatic glitch(input int w);
        sclk = 1'b1;
        #w sclk = 1'b0;
    endtask
    // Read/write flag, 7-bit address, data byte; keys and subcommands ride on it
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        sel(1'b0);
        for (int i = 15; i >= 0; i--) begin
            mosi = w[i];
            #80 sclk = 1'b1;
            r = {r[14:0], miso};
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        // Released line must not look like the last bit
        mosi = ~mosi;
        #400;
    endtask
endmodule

/* test/bms_cmd_core_test.sv */
// Self-checking bench for the command core with a host model
`timescale 1ns/10ps
module bms_cmd_core_test;
    import bms_cmd_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, filt_en = 1'b0;
    pwr_mode_t pwr_mode = pwr_normal;
    logic sclk, cs_n, mosi, miso, miso_oe, cfg_ready, sig_mismatch, bus_reset_evt, cmd_refused;
    sec_t sec_level;
    logic [7:0] ctrl_out, b;
    logic [7:0] rnd = 8'h14;
    logic [7:0] cfg_m [CFG_N];
    logic [15:0] sg [4];
    int failures = 0, checks = 0, nref = 0, nbr = 0, n;
    // Undriven output line shows a changing pattern
    wire miso_w = miso_oe ? miso : ~clk;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        nref <= nref + int'(cmd_refused === 1'b1);
        nbr <= nbr + int'(bus_reset_evt === 1'b1);
    end
    bms_cmd_core #(.BUS_RST_CYC(2000)) bms_cmd_core_i (.clk(clk), .nrst(nrst), .ce(ce),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .filt_en(filt_en), .pwr_mode(pwr_mode),
        .miso(miso), .miso_oe(miso_oe), .sec_level(sec_level), .cfg_ready(cfg_ready),
        .sig_mismatch(sig_mismatch), .bus_reset_evt(bus_reset_evt),
        .cmd_refused(cmd_refused), .ctrl_out(ctrl_out));
    host_spi_model host_spi_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_w));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] r;
        host_spi_model_i.xfer({1'b0, a, d}, r);
    endtask
    // Answer arrives in the second byte of the following frame
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic [15:0] r;
        host_spi_model_i.xfer({1'b1, a, 8'h00}, r);
        host_spi_model_i.xfer(16'h8000, r);
        d = r[7:0];
    endtask
    task automatic sub(input logic [15:0] c);
        cmd(CMD_SUB_LO, c[7:0]);
        cmd(CMD_SUB_HI, c[15:8]);
    endtask
    task automatic sig_rd(input logic [15:0] c, output logic [15:0] s);
        sub(c);
        rd(CMD_BLK_BASE, s[7:0]);
        rd(CMD_BLK_BASE + 7'h1, s[15:8]);
    endtask
    task automatic setmode(input pwr_mode_t m);
        @(negedge clk);
        pwr_mode = m;
        repeat (20) @(negedge clk);
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        while (cfg_ready !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (k == 300) begin
            failures++;
            stop_test();
        end
    endtask
    task automatic chk_cfg();
        logic [7:0] v;
        for (int i = 0; i < CFG_N; i++) begin
            rd(CMD_CFG_BASE + 7'(i), v);
            check(v, cfg_m[i]);
        end
    endtask
    initial begin
        #1000000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        wait_ready();
        check(sec_level, restricted_level);
        check(ctrl_out, CTRL_RST);
        rd(CMD_STATUS, b);
        check(b, 8'h04);
        rnd = lfsr(rnd);
        cmd(CMD_CTRL, rnd);
        check(ctrl_out, rnd);
        cmd(CMD_CFG_BASE, rnd);
        rd(CMD_CFG_BASE, b);
        check(b, 8'h00);
        sub(SUB_OTP_WRITE);
        sub(SUB_KEY_UA);
        sub(16'h7777);
        // Accepted subcommand between keys cancels the pair
        sig_rd(SUB_IROM_SIG, sg[0]);
        sub(SUB_KEY_UB);
        check(16'(nref), 16'd3);
        check(sec_level, restricted_level);
        sig_rd(SUB_DROM_SIG, sg[1]);
        sub(SUB_KEY_UA);
        sub(SUB_KEY_UB);
        check(sec_level, intermediate_level);
        for (int i = 0; i < CFG_N; i++) begin
            cfg_m[i] = CFG_DEFAULT[i*8 +: 8];
        end
        chk_cfg();
        for (int i = 0; i < CFG_N; i++) begin
            rnd = lfsr(rnd);
            cfg_m[i] = rnd;
            cmd(CMD_CFG_BASE + 7'(i), rnd);
        end
        chk_cfg();
        sub(SUB_CFG_STORE);
        sub(SUB_CFG_CHK);
        check(sig_mismatch, 1'b0);
        cfg_m[CAL_FIRST] = ~cfg_m[CAL_FIRST];
        cmd(CMD_CFG_BASE + 7'(CAL_FIRST), cfg_m[CAL_FIRST]);
        sub(SUB_CFG_CHK);
        check(sig_mismatch, 1'b0);
        cfg_m[0] = ~cfg_m[0];
        cmd(CMD_CFG_BASE, cfg_m[0]);
        sub(SUB_CFG_CHK);
        check(sig_mismatch, 1'b1);
        rd(CMD_BLK_BASE + 7'h2, b);
        check(b, 8'h01);
        sub(SUB_KEY_FA);
        sub(SUB_KEY_FB);
        check(sec_level, full_access_level);
        sub(SUB_OTP_WRITE);
        rd(CMD_STATUS, b);
        check(b, 8'h2e);
        setmode(pwr_sleep);
        setmode(deep_low_power_mode);
        setmode(pwr_normal);
        check(sec_level, full_access_level);
        chk_cfg();
        setmode(pwr_shutdown);
        check(ctrl_out, 8'h00);
        check(sec_level, restricted_level);
        setmode(pwr_normal);
        wait_ready();
        sub(SUB_KEY_UA);
        sub(SUB_KEY_UB);
        chk_cfg();
        sig_rd(SUB_DROM_SIG, sg[2]);
        check(sg[2], sg[1]);
        sig_rd(SUB_IROM_SIG, sg[3]);
        check(sg[3], sg[0]);
        @(negedge clk);
        filt_en = 1'b1;
        host_spi_model_i.sel(1'b0);
        repeat (900) @(negedge clk);
        host_spi_model_i.glitch(50);
        repeat (920) @(negedge clk);
        check(16'(nbr), 16'd0);
        n = 0;
        while (nbr == 0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(16'(nbr), 16'd1);
        host_spi_model_i.sel(1'b1);
        check(16'(nref), 16'd3);
        // Long pulse passes the filter while deselected
        host_spi_model_i.glitch(400);
        repeat (40) @(negedge clk);
        stop_test();
    end
endmodule
